/* File: pkg/ccc_pkg.sv */
package ccc_pkg;
	localparam int          CLK_MHZ         = 200;
	localparam int          CRC7_W          = 7;
	localparam logic [6:0]  CRC7_POLY       = 7'h09;
	localparam int          CRC16_W         = 16;
	localparam logic [15:0] CRC16_POLY      = 16'h1021;
	localparam int          CMD_BITS        = 48;
	localparam int          CMD_CRC_SPAN    = 40;
	localparam int          REG_CRC_SPAN    = 120;
	localparam int          CMD_DIR_POS     = 46;
	localparam int          CMD_IDX_POS     = 40;
	localparam int          CMD_ARG_POS     = 8;
	localparam int          TIMEOUT_MULT    = 10;
	localparam int          MAX_BLK_BYTES   = 2048;
	localparam logic [11:0] BASIC_CLASS     = 12'h001;
	localparam logic [5:0]  IDX_IDLE        = 6'h00;
	localparam int          FORCE_ERASE_MIN = 3;
	localparam longint      FORCE_ERASE_CYC = longint'(FORCE_ERASE_MIN) * 60 * 1000000 * CLK_MHZ;

	typedef enum logic [1:0] {
		CCC_BC   = 2'h0,
		CCC_BCR  = 2'h1,
		CCC_AC   = 2'h3,
		CCC_ADTC = 2'h2
	} ccc_cmd_type_t;

	typedef enum logic [1:0] {
		CCC_OP_READ  = 2'h0,
		CCC_OP_WRITE = 2'h1,
		CCC_OP_ERASE = 2'h3,
		CCC_OP_FORCE = 2'h2
	} ccc_op_t;
endpackage

/* File: pkg/ccc_if.sv */
`timescale 1ns/1ps
interface ccc_crc_if #(parameter int W = 7);
	logic         clear;
	logic         shift;
	logic         din;
	logic [W-1:0] crc;
	modport eng (input clear, input shift, input din, output crc);
	modport usr (output clear, output shift, output din, input crc);
endinterface

interface ccc_stream_if #(parameter int W = 40);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

/* File: core/ccc_crc.sv */
`timescale 1ns/1ps
module ccc_crc #(
	parameter int         W    = 7,
	parameter logic [W-1:0] POLY = 7'h09
) (
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_srst,
	// Serial engine
	ccc_crc_if.eng    c
);
	logic [W-1:0] base;

	assign base = c.clear ? '0 : c.crc;

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			c.crc <= '0;
		end else if (c.shift) begin
			c.crc <= {base[W-2:0], 1'b0} ^ ((c.din ^ base[W-1]) ? POLY : '0);
		end else if (c.clear) begin
			c.crc <= '0;
		end
	end

	property p_clear_zero;
		@(posedge i_clock) disable iff (i_srst) c.clear && !c.shift |=> c.crc == '0;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("crc not cleared");

	property p_poly;
		@(posedge i_clock) disable iff (i_srst)
		c.shift && c.din && (c.clear || c.crc == '0) |=> c.crc == POLY;
	endproperty
	a_poly: assert property (p_poly) else $error("crc generator wrong");
endmodule

/* File: core/ccc_buf.sv */
`timescale 1ns/1ps
module ccc_buf #(
	parameter int W = 40
) (
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_srst,
	// Fill and drain sides
	ccc_stream_if.snk s,
	ccc_stream_if.src q
);
	logic         v1;
	logic [W-1:0] d1;
	logic         push;
	logic         pop;

	assign s.ready = !v1;
	assign push    = s.valid && !v1;
	assign pop     = q.valid && q.ready;

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			q.valid <= 1'b0;
			v1      <= 1'b0;
			q.data  <= '0;
			d1      <= '0;
		end else if (pop) begin
			if (v1) begin
				q.data <= d1;
				v1     <= push;
				if (push) begin
					d1 <= s.data;
				end
			end else begin
				q.valid <= push;
				q.data  <= s.data;
			end
		end else if (push) begin
			if (!q.valid) begin
				q.valid <= 1'b1;
				q.data  <= s.data;
			end else begin
				v1 <= 1'b1;
				d1 <= s.data;
			end
		end
	end

	property p_hold;
		@(posedge i_clock) disable iff (i_srst) q.valid && !q.ready |=> q.valid && $stable(q.data);
	endproperty
	a_hold: assert property (p_hold) else $error("buffered word lost under stall");
endmodule

/* File: core/ccc_top.sv */
`timescale 1ns/1ps
// Functional notes
// - CRC7 on commands, responses, identity registers
// - CRC7 generator x7 plus x3 plus 1
// - CRC7 starts zero, leftmost bit first
// - CRC7 spans 40 or 120 bits
// - Data CRC16 generator x16 x12 x5 1
// - CRC16 cleared per block, first bit first
// - Blocks at most 2048 bytes
// - One CRC16 per line, sent together
// - Bad command CRC: silent, flag set
// - Illegal command: silent, flag set
// - Illegal: unsupported class, state, undefined index
// - Operations time out at ten times typical
// - Read time is time plus clocks
// - Program time is read times two to the multiplier
// - Erase time is blocks times write
// - Forced erase times out after 3 minutes
// - 48-bit frame: start, direction, index, argument
// - Frames sent leftmost bit first
// - Four command types
// - Basic class always supported and reported
// - Commands on command line, data on data
module ccc_top #(
	parameter int          LINES           = 8,
	parameter logic [11:0] CLASS_SET       = 12'h0ff,
	parameter longint      FORCE_ERASE_CYC = ccc_pkg::FORCE_ERASE_CYC
) (
	// Clock and reset
	input  wire logic                    i_clock,
	input  wire logic                    i_srst,
	// Card bus pins
	input  wire logic                    i_bus_clk,
	input  wire logic                    i_cmd,
	output logic                         o_cmd,
	output logic                         o_cmd_oe,
	input  wire logic [LINES-1:0]        i_dat,
	// Received commands
	output logic                         o_cmd_valid,
	input  wire logic                    i_cmd_ready,
	output logic [5:0]                   o_cmd_index,
	output logic [31:0]                  o_cmd_arg,
	output ccc_pkg::ccc_cmd_type_t       o_cmd_type,
	input  wire logic [63:0]             i_cmd_permitted,
	// Status
	input  wire logic                    i_status_clear,
	output logic                         o_crc_err,
	output logic                         o_illegal,
	output logic [11:0]                  o_command_class_set,
	// Response
	input  wire logic                    i_resp_valid,
	input  wire logic                    i_resp_long,
	input  wire logic                    i_resp_no_crc,
	input  wire logic [119:0]            i_resp_bits,
	output logic                         o_resp_ready,
	// Data block check
	input  wire logic                    i_blk_arm,
	input  wire logic [11:0]             i_blk_bytes,
	input  wire logic [1:0]              i_bus_width,
	output logic                         o_blk_done,
	output logic                         o_blk_crc_err,
	// Operation time-out
	input  wire logic                    i_op_start,
	input  wire ccc_pkg::ccc_op_t        i_op_kind,
	input  wire logic                    i_op_done,
	input  wire logic [31:0]             i_read_delay_time_param_cyc,
	input  wire logic [15:0]             i_read_delay_clock_param_clk,
	input  wire logic [2:0]              i_write_speed_multiplier,
	input  wire logic [15:0]             i_erase_blocks,
	output logic                         o_op_busy,
	output logic                         o_op_timeout
);
	function automatic logic [11:0] cmd_classes(input logic [5:0] idx);
		case (idx)
			6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0c,
			6'h0d, 6'h0e, 6'h0f, 6'h13: cmd_classes = 12'h001;
			6'h0b: cmd_classes = 12'h002;
			6'h10: cmd_classes = 12'h094;
			6'h11, 6'h12: cmd_classes = 12'h004;
			6'h14: cmd_classes = 12'h008;
			6'h17: cmd_classes = 12'h014;
			6'h18, 6'h19, 6'h1a, 6'h1b: cmd_classes = 12'h010;
			6'h1c, 6'h1d, 6'h1e: cmd_classes = 12'h040;
			6'h23, 6'h24, 6'h26: cmd_classes = 12'h020;
			6'h27, 6'h28: cmd_classes = 12'h200;
			6'h2a: cmd_classes = 12'h080;
			6'h37, 6'h38: cmd_classes = 12'h100;
			default: cmd_classes = 12'h000;
		endcase
	endfunction

	function automatic ccc_pkg::ccc_cmd_type_t cmd_type(input logic [5:0] idx);
		case (idx)
			6'h00, 6'h04: cmd_type = ccc_pkg::CCC_BC;
			6'h01, 6'h02, 6'h28: cmd_type = ccc_pkg::CCC_BCR;
			6'h08, 6'h0b, 6'h0e, 6'h11, 6'h12, 6'h13, 6'h14, 6'h18, 6'h19, 6'h1a, 6'h1b,
			6'h1e, 6'h2a, 6'h38: cmd_type = ccc_pkg::CCC_ADTC;
			default: cmd_type = ccc_pkg::CCC_AC;
		endcase
	endfunction

	function automatic logic [35:0] times_ten(input logic [31:0] v);
		times_ten = 36'(v) * 36'(ccc_pkg::TIMEOUT_MULT);
	endfunction

	localparam logic [11:0] CLS_EFF = CLASS_SET | ccc_pkg::BASIC_CLASS;

	// Pin synchronisers: bus clock, command line, data lines
	// Reset to the idle pin levels so that no false edge follows reset
	localparam logic [LINES+1:0] PIN_IDLE = {{(LINES + 1){1'b1}}, 1'b0};
	logic [LINES+1:0] s1, s2, s3, sv;
	logic             bclk_d, rise, fall, cbit;
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			s1     <= PIN_IDLE;
			s2     <= PIN_IDLE;
			s3     <= PIN_IDLE;
			sv     <= PIN_IDLE;
			bclk_d <= 1'b0;
		end else begin
			s1     <= {i_dat, i_cmd, i_bus_clk};
			s2     <= s1;
			s3     <= s2;
			sv     <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & sv);
			bclk_d <= sv[0];
		end
	end
	assign rise = sv[0] && !bclk_d;
	assign fall = !sv[0] && bclk_d;
	assign cbit = sv[1];

	// Command receiver
	ccc_crc_if #(ccc_pkg::CRC7_W) rcrc ();
	ccc_crc #(.W(ccc_pkg::CRC7_W), .POLY(ccc_pkg::CRC7_POLY)) u_rcrc (
		.i_clock (i_clock),
		.i_srst  (i_srst),
		.c       (rcrc)
	);
	ccc_stream_if #(40) sq ();
	ccc_stream_if #(40) oq ();
	ccc_buf #(.W(40)) u_buf (
		.i_clock (i_clock),
		.i_srst  (i_srst),
		.s       (sq),
		.q       (oq)
	);

	logic        rx_on, rx_done, pend, gate, rx_bad, rx_ill, tx_busy;
	logic [5:0]  rx_cnt;
	logic [47:0] rx_sr;
	logic [39:0] pend_d;
	logic [5:0]  rx_idx;

	// command line only, never while driving
	assign gate       = rise && !tx_busy && !o_cmd_oe;
	assign rx_idx     = rx_sr[ccc_pkg::CMD_IDX_POS +: 6];
	// start from zero with the start bit
	assign rcrc.clear = gate && !rx_on && !cbit && !pend;
	// only the first 40 frame bits
	assign rcrc.shift = rcrc.clear || (gate && rx_on && rx_cnt < 6'(ccc_pkg::CMD_CRC_SPAN));
	assign rcrc.din   = cbit;
	// direction, end bit and CRC7 field
	assign rx_bad     = !rx_sr[ccc_pkg::CMD_DIR_POS] || !rx_sr[0] || rx_sr[7:1] != rcrc.crc;
	assign rx_ill     = ~|(cmd_classes(rx_idx) & CLS_EFF) || !i_cmd_permitted[rx_idx];

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			rx_on   <= 1'b0;
			rx_cnt  <= '0;
			rx_sr   <= '0;
			rx_done <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (rcrc.clear) begin
				rx_on  <= 1'b1;
				rx_cnt <= 6'h01;
				rx_sr  <= {rx_sr[46:0], cbit};
			end else if (gate && rx_on) begin
				rx_sr  <= {rx_sr[46:0], cbit};
				rx_cnt <= rx_cnt + 6'h01;
				if (rx_cnt == 6'(ccc_pkg::CMD_BITS - 1)) begin
					rx_on   <= 1'b0;
					rx_done <= 1'b1;
				end
			end
		end
	end

	// bad or illegal frames are dropped
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			pend   <= 1'b0;
			pend_d <= '0;
		end else if (rx_done && !rx_bad && !rx_ill) begin
			pend   <= 1'b1;
			pend_d <= {rx_idx, rx_sr[ccc_pkg::CMD_ARG_POS +: 32], cmd_type(rx_idx)};
		end else if (sq.ready) begin
			pend <= 1'b0;
		end
	end
	assign sq.valid = pend;
	assign sq.data  = pend_d;
	assign oq.ready = i_cmd_ready;

	assign o_cmd_valid = oq.valid;
	assign o_cmd_index = oq.data[39:34];
	assign o_cmd_arg   = oq.data[33:2];
	assign o_cmd_type  = ccc_pkg::ccc_cmd_type_t'(oq.data[1:0]);

	// Status flags: a set in the clearing cycle wins; idle command clears
	logic st_clr;
	assign st_clr = i_status_clear || (rx_done && !rx_bad && !rx_ill && rx_idx == ccc_pkg::IDX_IDLE);
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_crc_err           <= 1'b0;
			o_illegal           <= 1'b0;
			o_command_class_set <= ccc_pkg::BASIC_CLASS;
		end else begin
			o_command_class_set <= CLS_EFF;
			if (rx_done && rx_bad) begin
				o_crc_err <= 1'b1;
			end else if (st_clr) begin
				o_crc_err <= 1'b0;
			end
			if (rx_done && !rx_bad && rx_ill) begin
				o_illegal <= 1'b1;
			end else if (st_clr) begin
				o_illegal <= 1'b0;
			end
		end
	end

	property p_crc_drop;
		@(posedge i_clock) disable iff (i_srst) rx_done && rx_bad && !pend |=> o_crc_err && !pend;
	endproperty
	a_crc_drop: assert property (p_crc_drop) else $error("bad frame not dropped");

	property p_illegal;
		@(posedge i_clock) disable iff (i_srst)
		rx_done && !rx_bad && rx_ill && !pend |=> o_illegal && !pend;
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal frame accepted");

	// Response transmitter, bits change on falling bus clock
	ccc_crc_if #(ccc_pkg::CRC7_W) tcrc ();
	ccc_crc #(.W(ccc_pkg::CRC7_W), .POLY(ccc_pkg::CRC7_POLY)) u_tcrc (
		.i_clock (i_clock),
		.i_srst  (i_srst),
		.c       (tcrc)
	);
	logic [127:0] tx_sr;
	logic [7:0]   tx_cnt, tx_n;
	logic         tx_nocrc;
	logic [7:0]   tail;

	// no CRC7 for the operating-conditions response
	assign tail       = {tx_nocrc ? 7'h7f : tcrc.crc, 1'b1};
	assign tcrc.clear = o_resp_ready && i_resp_valid;
	assign tcrc.shift = tx_busy && fall && tx_cnt < tx_n;
	assign tcrc.din   = tx_sr[127];

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			tx_busy      <= 1'b0;
			o_resp_ready <= 1'b0;
			o_cmd        <= 1'b1;
			o_cmd_oe     <= 1'b0;
			tx_sr        <= '0;
			tx_cnt       <= '0;
			tx_n         <= '0;
			tx_nocrc     <= 1'b0;
		end else if (!tx_busy) begin
			o_resp_ready <= !rx_on;
			if (o_resp_ready && i_resp_valid) begin
				o_resp_ready <= 1'b0;
				tx_busy      <= 1'b1;
				tx_cnt       <= '0;
				tx_nocrc     <= i_resp_no_crc;
				tx_n  <= i_resp_long ? 8'(ccc_pkg::REG_CRC_SPAN) : 8'(ccc_pkg::CMD_CRC_SPAN);
				tx_sr <= i_resp_long ? {i_resp_bits, 8'h00} : {i_resp_bits[39:0], 88'h0};
			end
		end else if (fall) begin
			tx_cnt <= tx_cnt + 8'h01;
			if (tx_cnt == tx_n + 8'h08) begin
				o_cmd_oe <= 1'b0;
				o_cmd    <= 1'b1;
				tx_busy  <= 1'b0;
			end else if (tx_cnt == tx_n) begin
				o_cmd         <= tail[7];
				tx_sr[127:121] <= tail[6:0];
			end else begin
				o_cmd_oe <= 1'b1;
				o_cmd    <= tx_sr[127];
				tx_sr    <= {tx_sr[126:0], 1'b0};
			end
		end
	end

	property p_end_bit;
		@(posedge i_clock) disable iff (i_srst) $fell(o_cmd_oe) |-> $past(o_cmd);
	endproperty
	a_end_bit: assert property (p_end_bit) else $error("response end bit not one");

	// Data block CRC16, one engine per line
	typedef enum logic [1:0] {D_IDLE = 2'h0, D_WAIT = 2'h1, D_DATA = 2'h3, D_CRC = 2'h2} ccc_dst_t;
	ccc_dst_t          d_st;
	logic [14:0]       d_cnt, d_len;
	logic [LINES-1:0]  act, line_ok;
	logic [LINES-1:0][15:0] rxc;
	logic [LINES-1:0]  dbit;

	assign dbit = sv[LINES+1:2];
	ccc_crc_if #(ccc_pkg::CRC16_W) dcrc [LINES] ();
	for (genvar g = 0; g < LINES; g++) begin : g_line
		ccc_crc #(.W(ccc_pkg::CRC16_W), .POLY(ccc_pkg::CRC16_POLY)) u_dcrc (
			.i_clock (i_clock),
			.i_srst  (i_srst),
			.c       (dcrc[g])
		);
		// cleared at arm, first data bit first
		assign dcrc[g].clear = i_blk_arm && d_st == D_IDLE;
		// each active line runs its own CRC16
		assign dcrc[g].shift = rise && d_st == D_DATA && act[g];
		assign dcrc[g].din   = dbit[g];
		assign line_ok[g]    = !act[g] || dcrc[g].crc == rxc[g];
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			d_st          <= D_IDLE;
			d_cnt         <= '0;
			d_len         <= '0;
			act           <= '0;
			rxc           <= '0;
			o_blk_done    <= 1'b0;
			o_blk_crc_err <= 1'b0;
		end else begin
			o_blk_done <= 1'b0;
			case (d_st)
				D_IDLE: begin
					if (i_blk_arm && i_blk_bytes != '0
						&& i_blk_bytes <= 12'(ccc_pkg::MAX_BLK_BYTES)) begin
						d_st  <= D_WAIT;
						d_len <= {i_blk_bytes, 3'h0} >> (i_bus_width == 2'h2 ? 3 :
							i_bus_width == 2'h1 ? 2 : 0);
						act   <= i_bus_width == 2'h2 ? LINES'(8'hff) :
							i_bus_width == 2'h1 ? LINES'(4'hf) : LINES'(1'b1);
					end
				end
				D_WAIT: if (rise && !dbit[0]) begin
					d_st  <= D_DATA;
					d_cnt <= '0;
				end
				D_DATA: if (rise) begin
					d_cnt <= d_cnt + 15'h1;
					if (d_cnt == d_len - 15'h1) begin
						d_st  <= D_CRC;
						d_cnt <= '0;
					end
				end
				D_CRC: if (rise) begin
					for (int i = 0; i < LINES; i++) begin
						rxc[i] <= {rxc[i][14:0], dbit[i]};
					end
					d_cnt <= d_cnt + 15'h1;
					if (d_cnt == 15'(ccc_pkg::CRC16_W - 1)) begin
						d_st <= D_IDLE;
					end
				end
				default: d_st <= D_IDLE;
			endcase
			if (d_st == D_IDLE && bclk_d && o_blk_done == 1'b0 && d_cnt == 15'(ccc_pkg::CRC16_W)) begin
				o_blk_done    <= 1'b1;
				o_blk_crc_err <= !(&line_ok);
				d_cnt         <= '0;
			end
		end
	end

	property p_blk_done;
		@(posedge i_clock) disable iff (i_srst)
		d_st == D_CRC && rise && d_cnt == 15'(ccc_pkg::CRC16_W - 1) |-> ##[1:40] o_blk_done;
	endproperty
	a_blk_done: assert property (p_blk_done) else $error("block result missing");

	// Operation time-out: time phase, then clock phase, repeated; forced erase is one long cycle count
	typedef enum logic [1:0] {T_IDLE = 2'h0, T_TIME = 2'h1, T_CLK = 2'h3, T_LONG = 2'h2} ccc_tst_t;
	ccc_tst_t    t_st;
	logic [35:0] t_cnt;
	logic [31:0] reps;

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			t_st         <= T_IDLE;
			t_cnt        <= '0;
			reps         <= '0;
			o_op_busy    <= 1'b0;
			o_op_timeout <= 1'b0;
		end else if (i_op_start) begin
			o_op_busy    <= 1'b1;
			o_op_timeout <= 1'b0;
			t_cnt        <= '0;
			case (i_op_kind)
				ccc_pkg::CCC_OP_FORCE: t_st <= T_LONG;
				default: t_st <= T_TIME;
			endcase
			case (i_op_kind)
				ccc_pkg::CCC_OP_WRITE: reps <= 32'h1 << i_write_speed_multiplier;
				ccc_pkg::CCC_OP_ERASE: reps <= 32'(i_erase_blocks) << i_write_speed_multiplier;
				default: reps <= 32'h1;
			endcase
		end else if (i_op_done) begin
			t_st      <= T_IDLE;
			o_op_busy <= 1'b0;
		end else begin
			case (t_st)
				T_IDLE: t_cnt <= '0;
				T_TIME: begin
					t_cnt <= t_cnt + 36'h1;
					if (t_cnt + 36'h1 >= times_ten(i_read_delay_time_param_cyc)) begin
						t_st  <= T_CLK;
						t_cnt <= '0;
					end
				end
				T_CLK: begin
					if (rise) begin
						t_cnt <= t_cnt + 36'h1;
					end
					if (t_cnt >= times_ten(32'(i_read_delay_clock_param_clk))) begin
						t_cnt <= '0;
						reps  <= reps - 32'h1;
						t_st  <= T_TIME;
						if (reps <= 32'h1) begin
							t_st         <= T_IDLE;
							o_op_busy    <= 1'b0;
							o_op_timeout <= 1'b1;
						end
					end
				end
				T_LONG: begin
					t_cnt <= t_cnt + 36'h1;
					if (t_cnt == 36'(FORCE_ERASE_CYC - 1)) begin
						t_st         <= T_IDLE;
						o_op_busy    <= 1'b0;
						o_op_timeout <= 1'b1;
					end
				end
				default: t_st <= T_IDLE;
			endcase
		end
	end

	property p_force;
		@(posedge i_clock) disable iff (i_srst)
		$rose(o_op_timeout) && $past(t_st) == T_LONG |-> $past(t_cnt) == 36'(FORCE_ERASE_CYC - 1);
	endproperty
	a_force: assert property (p_force) else $error("forced erase limit wrong");

	property p_timeout_idle;
		@(posedge i_clock) disable iff (i_srst) $rose(o_op_timeout) |-> !o_op_busy && t_st == T_IDLE;
	endproperty
	a_timeout_idle: assert property (p_timeout_idle) else $error("timed-out op not abandoned");
endmodule

/* File: testbench/ccc_host.sv */
`timescale 1ns/1ps
module ccc_host (
	// Card bus
	output logic       o_bus_clk,
	output logic       o_cmd,
	output logic [7:0] o_dat
);
	initial begin
		o_bus_clk = 1'b0;
		o_cmd = 1'b1;
		o_dat = 8'hff;
	end
	task automatic tick(input logic c, input logic [7:0] d);
		o_cmd = c;
		o_dat = d;
		#80 o_bus_clk = 1'b1;
		#80 o_bus_clk = 1'b0;
	endtask
	task automatic idle(input int n);
		repeat (n) tick(1'b1, 8'hff);
	endtask
	// serial remainder, register starts at zero
	function automatic logic [15:0] crc(input logic [119:0] v, input int n, input int w);
		logic [15:0] c;
		logic        f;
		c = '0;
		for (int i = n - 1; i >= 0; i--) begin
			f = c[w-1] ^ v[i];
			c = {c[14:0], 1'b0} ^ (f ? (w == 7 ? 16'h0009 : 16'h1021) : 16'h0000);
		end
		return (w == 7) ? {9'h000, c[6:0]} : c;
	endfunction
	task automatic send_cmd(input logic [5:0] idx, input logic [31:0] arg, input logic bad);
		logic [47:0] f;
		logic [15:0] k;
		f[47:8] = {2'b01, idx, arg};
		k = crc({80'h0, f[47:8]}, 40, 7);
		f[7:1] = k[6:0] ^ {6'h00, bad};
		f[0] = 1'b1;
		for (int i = 47; i >= 0; i--) tick(f[i], 8'hff);
	endtask
	// one byte on line 0, check value after data
	task automatic send_blk(input logic [7:0] b, input logic bad);
		logic [15:0] k;
		k = crc({112'h0, b}, 8, 16) ^ {15'h0000, bad};
		tick(1'b1, 8'hfe);
		for (int i = 7; i >= 0; i--) tick(1'b1, {7'h7f, b[i]});
		for (int i = 15; i >= 0; i--) tick(1'b1, {7'h7f, k[i]});
		tick(1'b1, 8'hff);
	endtask
	// eight lines, one bit each, every line with its own check value
	task automatic send_wide(input logic [7:0] b, input logic bad);
		logic [15:0] k [8];
		logic [7:0]  c;
		for (int j = 0; j < 8; j++) k[j] = crc({119'h0, b[j]}, 1, 16);
		k[7][0] = k[7][0] ^ bad;
		tick(1'b1, 8'h00);
		tick(1'b1, b);
		for (int i = 15; i >= 0; i--) begin
			for (int j = 0; j < 8; j++) c[j] = k[j][i];
			tick(1'b1, c);
		end
		tick(1'b1, 8'hff);
	endtask
endmodule

/* File: testbench/ccc_top_tb.sv */
`timescale 1ns/1ps
module ccc_top_tb;
	logic i_clock, i_srst, i_bus_clk, i_cmd, o_cmd, o_cmd_oe, o_cmd_valid, i_cmd_ready, h_cmd;
	logic i_status_clear, o_crc_err, o_illegal, i_resp_valid, i_resp_long, i_resp_no_crc;
	logic o_resp_ready, i_blk_arm, o_blk_done, o_blk_crc_err, i_op_start, i_op_done;
	logic o_op_busy, o_op_timeout, got_done, got_err;
	logic [5:0]             o_cmd_index;
	logic [31:0]            o_cmd_arg, i_read_delay_time_param_cyc;
	logic [63:0]            i_cmd_permitted;
	logic [11:0]            o_command_class_set, i_blk_bytes;
	logic [119:0]           i_resp_bits;
	logic [7:0]             i_dat;
	logic [15:0]            i_read_delay_clock_param_clk, i_erase_blocks, k;
	logic [2:0]             i_write_speed_multiplier;
	logic [1:0]             i_bus_width;
	logic [47:0]            rsp;
	ccc_pkg::ccc_cmd_type_t o_cmd_type;
	ccc_pkg::ccc_op_t       i_op_kind;
	int                     errors, checks_done;

	assign i_cmd = o_cmd_oe ? o_cmd : h_cmd;
	ccc_host host (.o_bus_clk(i_bus_clk), .o_cmd(h_cmd), .o_dat(i_dat));
	ccc_top #(.FORCE_ERASE_CYC(200)) DUT (.i_clock, .i_srst, .i_bus_clk, .i_cmd, .o_cmd,
		.o_cmd_oe, .i_dat, .o_cmd_valid, .i_cmd_ready, .o_cmd_index, .o_cmd_arg, .o_cmd_type,
		.i_cmd_permitted, .i_status_clear, .o_crc_err, .o_illegal, .o_command_class_set,
		.i_resp_valid, .i_resp_long, .i_resp_no_crc, .i_resp_bits, .o_resp_ready, .i_blk_arm,
		.i_blk_bytes, .i_bus_width, .o_blk_done, .o_blk_crc_err, .i_op_start, .i_op_kind,
		.i_op_done, .i_read_delay_time_param_cyc, .i_read_delay_clock_param_clk, .i_write_speed_multiplier, .i_erase_blocks,
		.o_op_busy, .o_op_timeout);

	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end
	always @(posedge i_bus_clk) if (o_cmd_oe === 1'b1) rsp <= {rsp[46:0], o_cmd};
	always @(posedge i_clock) if (o_blk_done === 1'b1) begin
		got_done <= 1'b1;
		got_err <= o_blk_crc_err;
	end

	task automatic compare(input logic [47:0] got, input logic [47:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("errors %0d checks_done %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic cmd(input logic [5:0] idx, input logic [31:0] a, input logic bad);
		host.send_cmd(idx, a, bad);
		repeat (10) @(posedge i_clock);
	endtask
	task automatic pop(input logic [5:0] idx, input logic [1:0] ty, input logic [31:0] a);
		compare({o_cmd_valid, o_cmd_type, o_cmd_index, o_cmd_arg}, {1'b1, ty, idx, a}, "word");
		@(posedge i_clock) i_cmd_ready <= 1'b1;
		@(posedge i_clock) i_cmd_ready <= 1'b0;
		repeat (4) @(posedge i_clock);
	endtask
	task automatic t_buffer;
		cmd(6'h02, 32'h0, 1'b0);
		cmd(6'h03, 32'hbeef0000, 1'b0);
		cmd(6'h11, 32'h12345678, 1'b0);
		cmd(6'h00, 32'h0, 1'b0);
		pop(6'h02, 2'h1, 32'h0);
		pop(6'h03, 2'h3, 32'hbeef0000);
		pop(6'h11, 2'h2, 32'h12345678);
		compare(o_cmd_valid, 1'b0, "overflow");
	endtask
	task automatic t_errors;
		cmd(6'h03, 32'h1, 1'b1);
		compare({o_cmd_valid, o_crc_err, o_illegal}, 3'b010, "bad crc");
		cmd(6'h2c, 32'h0, 1'b0);
		compare({o_cmd_valid, o_crc_err, o_illegal}, 3'b011, "undefined");
		cmd(6'h00, 32'h0, 1'b0);
		pop(6'h00, 2'h0, 32'h0);
		compare({o_crc_err, o_illegal}, 2'b00, "idle clears");
		cmd(6'h37, 32'h0, 1'b0);
		compare({o_cmd_valid, o_illegal}, 2'b01, "class");
		@(posedge i_clock) i_status_clear <= 1'b1;
		@(posedge i_clock) i_status_clear <= 1'b0;
		i_cmd_permitted[3] <= 1'b0;
		cmd(6'h03, 32'h0, 1'b0);
		compare({o_cmd_valid, o_illegal}, 2'b01, "state");
		i_cmd_permitted[3] <= 1'b1;
	endtask
	task automatic t_resp(input logic nc);
		k = host.crc({80'h0, 40'h3f12345678}, 40, 7);
		compare(o_resp_ready, 1'b1, "resp ready");
		@(posedge i_clock) begin
			i_resp_valid <= 1'b1;
			i_resp_no_crc <= nc;
			i_resp_bits <= {80'h0, 40'h3f12345678};
		end
		@(posedge i_clock) i_resp_valid <= 1'b0;
		host.idle(52);
		compare(rsp, {40'h3f12345678, nc ? 7'h7f : k[6:0], 1'b1}, "response");
	endtask
	task automatic blk(input logic [7:0] b, input logic bad, input logic wide);
		got_done = 1'b0;
		@(posedge i_clock) begin
			i_bus_width <= wide ? 2'h2 : 2'h0;
			i_blk_arm <= 1'b1;
		end
		@(posedge i_clock) i_blk_arm <= 1'b0;
		if (wide) host.send_wide(b, bad);
		else host.send_blk(b, bad);
		repeat (10) @(posedge i_clock);
		compare({got_done, got_err}, {1'b1, bad}, "block");
	endtask
	// Read deadline 10*read_delay_time_param cycles plus 10*read_delay_clock_param bus clock rises
	task automatic t_clkpart;
		@(posedge i_clock) begin
			i_read_delay_clock_param_clk <= 16'h0001;
			i_op_kind <= ccc_pkg::CCC_OP_READ;
			i_op_start <= 1'b1;
		end
		@(posedge i_clock) i_op_start <= 1'b0;
		host.idle(9);
		compare({o_op_busy, o_op_timeout}, 2'b10, "clock part early");
		host.idle(3);
		compare({o_op_busy, o_op_timeout}, 2'b01, "clock part late");
		@(posedge i_clock) i_read_delay_clock_param_clk <= 16'h0000;
	endtask
	// Deadlines: read_delay_time_param 5 gives 50 cycles per access
	task automatic op(input ccc_pkg::ccc_op_t kd, input int d, input logic fin);
		@(posedge i_clock) begin
			i_op_kind <= kd;
			i_op_start <= 1'b1;
		end
		@(posedge i_clock) i_op_start <= 1'b0;
		repeat (d * 9 / 10) @(posedge i_clock);
		compare({o_op_busy, o_op_timeout}, 2'b10, "early");
		@(posedge i_clock) i_op_done <= fin;
		@(posedge i_clock) i_op_done <= 1'b0;
		repeat (d / 5 + 4) @(posedge i_clock);
		compare({o_op_busy, o_op_timeout}, {1'b0, ~fin}, "late");
	endtask

	initial begin
		{i_srst, i_cmd_ready, i_status_clear, i_resp_valid, i_resp_long} = 5'h10;
		{i_resp_no_crc, i_blk_arm, i_op_start, i_op_done, got_done, got_err} = 6'h00;
		i_cmd_permitted = '1;
		i_resp_bits = '0;
		{i_blk_bytes, i_bus_width, i_read_delay_clock_param_clk} = {12'h001, 2'h0, 16'h0000};
		{i_read_delay_time_param_cyc, i_write_speed_multiplier, i_erase_blocks} = {32'h5, 3'h1, 16'h2};
		i_op_kind = ccc_pkg::CCC_OP_READ;
		{errors, checks_done, rsp} = '0;
		repeat (10) @(posedge i_clock);
		i_srst <= 1'b0;
		repeat (8) @(posedge i_clock);
		compare(o_command_class_set, 12'h0ff, "classes");
		t_buffer();
		t_errors();
		t_resp(1'b0);
		t_resp(1'b1);
		blk(8'ha5, 1'b0, 1'b0);
		blk(8'h3c, 1'b1, 1'b0);
		blk(8'h5a, 1'b0, 1'b1);
		blk(8'h5a, 1'b1, 1'b1);
		op(ccc_pkg::CCC_OP_READ, 50, 1'b0);
		op(ccc_pkg::CCC_OP_READ, 50, 1'b1);
		op(ccc_pkg::CCC_OP_WRITE, 100, 1'b0);
		op(ccc_pkg::CCC_OP_ERASE, 200, 1'b0);
		op(ccc_pkg::CCC_OP_FORCE, 200, 1'b0);
		t_clkpart();
		end_of_test();
	end
	// give up when the card stays silent
	initial begin
		#400000;
		errors++;
		end_of_test();
	end
endmodule
